// file: shared/pps_regs.svh
// Constants of the power-path sequencer: offsets, fields, resets, timing.
//
// Contract
// - Start on request low without valid adapter, or on valid adapter arrival.
// - Pushbutton start switches the system rail on before any regulator.
// - Rail at 90% enables regulators one, three, five while group enable low.
// - Always-on group good starts 800 ms long reset hold, then releases it.
// - After long reset release, switchable group follows its enable input.
// - Switchable group good starts 10 ms timer, then short reset releases.
// - Request state is latched while adapter or battery stays connected.
// - Adapter above threshold turns system on; rail fed from adapter or battery.
// - Path select low with adapter feeds rail through the internal regulator.
// - Path select high or software force ties battery straight to the rail.
// - No adapter while enabled connects the rail directly to the battery.
// - Adapter start enables charger on adapter valid, raises charge indicator.
// - Battery only: always-on enable held low powers the device down.
// - Valid adapter refuses power-down; group enables still gate their groups.
// - Adapter removal powers down unless latched; a mere sag keeps power on.
// - Shutdown discharges every regulator output through its pull-down path.
// - Battery only puts charger to sleep and runs regulators from battery.
// - Adapter present runs converters from adapter, battery off the converters.
`ifndef PPS_REGS_SVH
`define PPS_REGS_SVH

// Register map, byte addresses
`define PPS_ADDR_CTRL 8'h00
`define PPS_ADDR_STATUS 8'h04

// Control field positions and reset value
`define PPS_CTRL_FORCE_BAT 0
`define PPS_CTRL_RESET 32'h00000000

// Pin synchroniser reset: active-low request and enables read as released
`define PPS_PINS_IDLE 10'h380

// Status field positions
`define PPS_ST_STATE_LSB 0
`define PPS_ST_LATCHED 8
`define PPS_ST_RAIL_ADP 9
`define PPS_ST_RAIL_BAT 10
`define PPS_ST_LONG_RST 11
`define PPS_ST_SHORT_RST 12

// Timing: clock rate and printed times
`define PPS_CLK_HZ 64'd20000000
`define PPS_LONG_RESET_MS 64'd800
`define PPS_SHORT_RESET_MS 64'd10
`define PPS_POWER_DOWN_MS 64'd1000
`define PPS_MS_TO_CYC(ms) (((ms) * `PPS_CLK_HZ) / 64'd1000)

`endif

// file: shared/pps_pkg.sv
// Types shared by the power-path sequencer files.
package pps_pkg;

    // Sequencer states, one-hot
    typedef enum logic [4:0] {
        PPS_OFF = 5'b00001,
        PPS_RAIL_UP = 5'b00010,
        PPS_AON_UP = 5'b00100,
        PPS_LONG_WAIT = 5'b01000,
        PPS_RUN = 5'b10000
    } pps_state_e;

    // Pins arriving from outside the clock domain
    typedef struct packed {
        logic system_power_request_n;
        logic always_on_group_enable_n;
        logic switchable_group_enable_n;
        logic adapter_connected;
        logic adapter_valid;
        logic battery_present;
        logic path_select;
        logic system_rail_good;
        logic always_on_group_good;
        logic switchable_group_good;
    } pps_pins_s;

    // Power-path switch controls
    typedef struct packed {
        logic rail_from_adapter;
        logic rail_from_battery;
        logic converters_from_adapter;
        logic converters_from_battery;
    } pps_path_s;

endpackage : pps_pkg

// file: rtl/pps_timer.sv
// Delay timer: counts while run is high, done once the count is reached.
module pps_timer #(
    parameter int unsigned CYCLES = 32'd1
) (
    input logic sys_clk_i,
    input logic rst_n_i,
    input logic run_i,
    output logic done_o
);

    logic [31:0] count;
    logic [31:0] next_count;
    logic at_end;

    // Saturate at the end so done stays high while run stays high
    assign at_end = (count == CYCLES);
    assign next_count = !run_i ? 32'h00000000 :
                        at_end ? count : count + 32'h00000001;
    assign done_o = at_end && run_i;

    // Counter register
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            count <= 32'h00000000;
        end else begin
            count <= next_count;
        end
    end

endmodule : pps_timer

// file: rtl/pps_sequencer.sv
// Power-path selection and start-up/shut-down sequencer top level.
//
// The implementer's own choices: the register addresses and the strobed register port.
`include "pps_regs.svh"

module pps_sequencer #(
    parameter int unsigned LONG_RESET_CYCLES =
        32'(`PPS_MS_TO_CYC(`PPS_LONG_RESET_MS)),
    parameter int unsigned SHORT_RESET_CYCLES =
        32'(`PPS_MS_TO_CYC(`PPS_SHORT_RESET_MS)),
    parameter int unsigned POWER_DOWN_CYCLES =
        32'(`PPS_MS_TO_CYC(`PPS_POWER_DOWN_MS))
) (
    input logic sys_clk_i,
    input logic rst_n_i,
    input pps_pkg::pps_pins_s pins_i,
    input logic [7:0] addr_i,
    input logic [31:0] wr_data_i,
    input logic wr_en_i,
    input logic rd_en_i,
    output logic [31:0] rd_data_o,
    output pps_pkg::pps_path_s path_o,
    output logic [2:0] always_on_group_en_o,
    output logic [2:0] switchable_group_en_o,
    output logic [5:0] discharge_en_o,
    output logic long_power_reset_n_o,
    output logic short_processor_reset_n_o,
    output logic charger_enable_o,
    output logic charger_sleep_o,
    output logic charge_indicator_o
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    pps_pkg::pps_pins_s pins_meta;
    pps_pkg::pps_pins_s pins_q;

    // Two stages; only the second stage is read by logic
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            pins_meta <= `PPS_PINS_IDLE;
            pins_q <= `PPS_PINS_IDLE;
        end else begin
            pins_meta <= pins_i;
            pins_q <= pins_meta;
        end
    end

    // Named views of the synchronised pins
    logic req_low;
    logic aon_req;
    logic sw_req;
    logic adp_conn;
    logic adp_valid;
    logic bat_ok;
    logic path_sel;
    logic rail_good;
    logic aon_good;
    logic sw_good;

    assign req_low = !pins_q.system_power_request_n;
    assign aon_req = !pins_q.always_on_group_enable_n;
    assign sw_req = !pins_q.switchable_group_enable_n;
    assign adp_conn = pins_q.adapter_connected;
    assign adp_valid = pins_q.adapter_valid;
    assign bat_ok = pins_q.battery_present;
    assign path_sel = pins_q.path_select;
    assign rail_good = pins_q.system_rail_good;
    assign aon_good = pins_q.always_on_group_good;
    assign sw_good = pins_q.switchable_group_good;

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    logic [31:0] ctrl;
    logic [31:0] next_ctrl;
    logic force_bat;
    logic wr_ctrl;

    // Only the force bit is writable; other bits stay zero
    assign wr_ctrl = wr_en_i && (addr_i == `PPS_ADDR_CTRL);
    assign next_ctrl = wr_ctrl ?
        (wr_data_i & (32'h00000001 << `PPS_CTRL_FORCE_BAT)) : ctrl;
    assign force_bat = ctrl[`PPS_CTRL_FORCE_BAT];

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            ctrl <= `PPS_CTRL_RESET;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    // ------------------------------------------------------------------
    // Supply conditions
    // ------------------------------------------------------------------
    logic any_supply;
    logic battery_only;

    // Battery alone: adapter absent or below its threshold
    assign any_supply = adp_conn || bat_ok;
    assign battery_only = bat_ok && !adp_valid;

    // ------------------------------------------------------------------
    // Request latch
    // ------------------------------------------------------------------
    logic latched;
    logic next_latched;
    logic latch_set;
    logic latch_clr;
    logic pd_done;

    // Set wins over clear so a press during a power-down is kept
    assign latch_set = req_low && any_supply;
    assign latch_clr = !any_supply || pd_done;
    assign next_latched = latch_set ? 1'b1 :
                          latch_clr ? 1'b0 : latched;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            latched <= 1'b0;
        end else begin
            latched <= next_latched;
        end
    end

    // ------------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------------
    pps_pkg::pps_state_e state;
    pps_pkg::pps_state_e next_state;
    logic powered;
    logic long_done;
    logic short_done;
    logic start_req;
    logic button_start;
    logic adapter_start;
    logic shutdown;
    logic removal_off;

    assign button_start = req_low && !adp_valid && bat_ok;
    assign adapter_start = adp_valid;
    assign start_req = button_start || adapter_start;

    // Sag keeps connection, so only a real removal drops an unlatched system
    assign removal_off = !adp_conn && !latched;
    // A valid adapter blocks every power-down path
    assign shutdown = !adp_valid &&
        (!any_supply || removal_off || pd_done);

    assign powered = (state != pps_pkg::PPS_OFF);

    // Leaves off on a start request, then advances only on power-good inputs and timer ends
    always_comb begin
        next_state = state;
        unique case (state)
            pps_pkg::PPS_OFF: begin
                if (start_req) begin
                    next_state = pps_pkg::PPS_RAIL_UP;
                end
            end
            pps_pkg::PPS_RAIL_UP: begin
                if (rail_good) begin
                    next_state = pps_pkg::PPS_AON_UP;
                end
            end
            pps_pkg::PPS_AON_UP: begin
                if (aon_good && aon_req) begin
                    next_state = pps_pkg::PPS_LONG_WAIT;
                end
            end
            pps_pkg::PPS_LONG_WAIT: begin
                if (long_done) begin
                    next_state = pps_pkg::PPS_RUN;
                end
            end
            pps_pkg::PPS_RUN: begin
                next_state = pps_pkg::PPS_RUN;
            end
            default: begin
                next_state = pps_pkg::PPS_OFF;
            end
        endcase
        // Shutdown overrides any stage of the sequence
        if (powered && shutdown) begin
            next_state = pps_pkg::PPS_OFF;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            state <= pps_pkg::PPS_OFF;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------------
    logic long_run;
    logic short_run;
    logic pd_run;
    logic in_run;

    assign in_run = (state == pps_pkg::PPS_RUN);
    assign long_run = (state == pps_pkg::PPS_LONG_WAIT);
    assign short_run = in_run && sw_req && sw_good;
    // Holding the always-on enable low on battery alone counts down
    assign pd_run = in_run && battery_only && aon_req;

    pps_timer #(
        .CYCLES(LONG_RESET_CYCLES)
    ) u_long_timer (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .run_i(long_run),
        .done_o(long_done)
    );

    pps_timer #(
        .CYCLES(SHORT_RESET_CYCLES)
    ) u_short_timer (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .run_i(short_run),
        .done_o(short_done)
    );

    pps_timer #(
        .CYCLES(POWER_DOWN_CYCLES)
    ) u_pd_timer (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .run_i(pd_run),
        .done_o(pd_done)
    );

    // ------------------------------------------------------------------
    // Regulator group enables
    // ------------------------------------------------------------------
    logic aon_stage;
    logic aon_on;
    logic sw_on;
    logic [2:0] next_aon_en;
    logic [2:0] next_sw_en;

    // Rail stage powers nothing but the rail itself
    assign aon_stage = (state == pps_pkg::PPS_AON_UP) ||
                       (state == pps_pkg::PPS_LONG_WAIT) || in_run;
    assign aon_on = aon_stage && aon_req;
    // Gated by the long reset so an early host enable does nothing
    assign sw_on = in_run && sw_req;
    assign next_aon_en = {3{aon_on}};
    assign next_sw_en = {3{sw_on}};

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            always_on_group_en_o <= 3'h0;
            switchable_group_en_o <= 3'h0;
        end else begin
            always_on_group_en_o <= next_aon_en;
            switchable_group_en_o <= next_sw_en;
        end
    end

    // Every disabled output is pulled down to empty its capacitor
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            discharge_en_o <= 6'h3F;
        end else begin
            discharge_en_o <= ~{next_sw_en, next_aon_en};
        end
    end

    // ------------------------------------------------------------------
    // Processor resets
    // ------------------------------------------------------------------
    logic next_long_rst_n;
    logic next_short_rst_n;

    assign next_long_rst_n = in_run;
    // Short reset falls again if the switchable group drops
    assign next_short_rst_n = in_run && short_done;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            long_power_reset_n_o <= 1'b0;
            short_processor_reset_n_o <= 1'b0;
        end else begin
            long_power_reset_n_o <= next_long_rst_n;
            short_processor_reset_n_o <= next_short_rst_n;
        end
    end

    // ------------------------------------------------------------------
    // Power path
    // ------------------------------------------------------------------
    pps_pkg::pps_path_s next_path;
    logic use_adapter_rail;

    // Regulated adapter feed unless the pin or software picks battery
    assign use_adapter_rail = adp_valid && !path_sel && !force_bat;

    always_comb begin
        next_path = '0;
        if (powered) begin
            next_path.rail_from_adapter = use_adapter_rail;
            // Battery switch closes for force, pin high or no adapter
            next_path.rail_from_battery = !use_adapter_rail;
            next_path.converters_from_adapter = adp_valid;
            next_path.converters_from_battery = !adp_valid;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            path_o <= '0;
        end else begin
            path_o <= next_path;
        end
    end

    // ------------------------------------------------------------------
    // Charger control
    // ------------------------------------------------------------------
    logic next_chg_en;
    logic next_chg_sleep;

    assign next_chg_en = adp_valid;
    // Sleep saves battery current whenever the adapter is gone
    assign next_chg_sleep = !adp_valid;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            charger_enable_o <= 1'b0;
            charger_sleep_o <= 1'b1;
            charge_indicator_o <= 1'b0;
        end else begin
            charger_enable_o <= next_chg_en;
            charger_sleep_o <= next_chg_sleep;
            charge_indicator_o <= next_chg_en;
        end
    end

    // ------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------
    logic [31:0] status;
    logic [31:0] next_rd_data;
    logic rd_ctrl;
    logic rd_status;

    // Status shows live sequencer state and path outputs
    always_comb begin
        status = 32'h00000000;
        status[`PPS_ST_STATE_LSB +: 5] = state;
        status[`PPS_ST_LATCHED] = latched;
        status[`PPS_ST_RAIL_ADP] = path_o.rail_from_adapter;
        status[`PPS_ST_RAIL_BAT] = path_o.rail_from_battery;
        status[`PPS_ST_LONG_RST] = long_power_reset_n_o;
        status[`PPS_ST_SHORT_RST] = short_processor_reset_n_o;
    end

    // Unmapped addresses and idle cycles read as zero
    assign rd_ctrl = rd_en_i && (addr_i == `PPS_ADDR_CTRL);
    assign rd_status = rd_en_i && (addr_i == `PPS_ADDR_STATUS);
    assign next_rd_data = rd_ctrl ? ctrl :
                          rd_status ? status : 32'h00000000;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            rd_data_o <= 32'h00000000;
        end else begin
            rd_data_o <= next_rd_data;
        end
    end

endmodule : pps_sequencer

// file: verif/pps_sequencer_asserts.sv
// Port checks for the power-path sequencer.
module pps_sequencer_asserts #(
    parameter int unsigned LONG_RESET_CYCLES = 32'd40,
    parameter int unsigned SHORT_RESET_CYCLES = 32'd10,
    parameter int unsigned POWER_DOWN_CYCLES = 32'd30
) (
    input logic sys_clk_i,
    input logic rst_n_i,
    input pps_pkg::pps_pins_s pins_i,
    input pps_pkg::pps_path_s path_o,
    input logic [2:0] always_on_group_en_o,
    input logic [2:0] switchable_group_en_o,
    input logic [5:0] discharge_en_o,
    input logic long_power_reset_n_o,
    input logic short_processor_reset_n_o,
    input logic charger_enable_o,
    input logic charger_sleep_o,
    input logic charge_indicator_o
);
    logic [31:0] hold_cnt;
    logic [31:0] sw_cnt;
    logic rail_on;
    assign rail_on = path_o.rail_from_adapter | path_o.rail_from_battery;
    // Cycles spent with each group up while its reset is still held
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || always_on_group_en_o != 3'h7 || long_power_reset_n_o)
            hold_cnt <= 32'h0;
        else
            hold_cnt <= hold_cnt + 32'h1;
        if (!rst_n_i || switchable_group_en_o != 3'h7
            || short_processor_reset_n_o)
            sw_cnt <= 32'h0;
        else
            sw_cnt <= sw_cnt + 32'h1;
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_aon_start;
        $rose(always_on_group_en_o == 3'h7);
    endsequence
    sequence s_sw_start;
        $rose(switchable_group_en_o != 3'h0);
    endsequence
    property p_rail_first;
        s_aon_start |-> $past(rail_on) && $past(pins_i.system_rail_good);
    endproperty
    a_rail_first: assert property (p_rail_first)
        else $error("always-on group enabled before rail good");
    property p_aon_gate;
        pins_i.always_on_group_enable_n [*6] |-> always_on_group_en_o == 3'h0;
    endproperty
    a_aon_gate: assert property (p_aon_gate)
        else $error("always-on group on with enable high");
    property p_sw_gate;
        pins_i.switchable_group_enable_n [*6]
            |-> switchable_group_en_o == 3'h0;
    endproperty
    a_sw_gate: assert property (p_sw_gate)
        else $error("switchable group on with enable high");
    property p_sw_after_long;
        s_sw_start |-> long_power_reset_n_o;
    endproperty
    a_sw_after_long: assert property (p_sw_after_long)
        else $error("switchable group before long reset release");
    property p_long_hold;
        $rose(long_power_reset_n_o)
            |-> hold_cnt >= LONG_RESET_CYCLES && always_on_group_en_o == 3'h7;
    endproperty
    a_long_hold: assert property (p_long_hold)
        else $error("long reset released early");
    property p_short_hold;
        $rose(short_processor_reset_n_o)
            |-> sw_cnt >= SHORT_RESET_CYCLES && long_power_reset_n_o;
    endproperty
    a_short_hold: assert property (p_short_hold)
        else $error("short reset released early");
    property p_discharge;
        discharge_en_o == ~{switchable_group_en_o, always_on_group_en_o};
    endproperty
    a_discharge: assert property (p_discharge)
        else $error("discharge path not opposite of enable");
    property p_charger;
        charge_indicator_o == charger_enable_o
            && charger_sleep_o == !charger_enable_o;
    endproperty
    a_charger: assert property (p_charger)
        else $error("charger controls disagree");
    property p_paths;
        !(path_o.converters_from_adapter && path_o.converters_from_battery)
            && !(path_o.rail_from_adapter && path_o.rail_from_battery);
    endproperty
    a_paths: assert property (p_paths)
        else $error("two sources switched on together");
    property p_adapter_keeps;
        charger_enable_o && $past(charger_enable_o) && $past(rail_on)
            |-> rail_on && path_o.converters_from_adapter;
    endproperty
    a_adapter_keeps: assert property (p_adapter_keeps)
        else $error("power lost with valid adapter");
    c_short: cover property ($rose(short_processor_reset_n_o));
endmodule : pps_sequencer_asserts

bind pps_sequencer pps_sequencer_asserts #(
    .LONG_RESET_CYCLES(LONG_RESET_CYCLES),
    .SHORT_RESET_CYCLES(SHORT_RESET_CYCLES),
    .POWER_DOWN_CYCLES(POWER_DOWN_CYCLES)
) u_chk (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .pins_i(pins_i),
    .path_o(path_o),
    .always_on_group_en_o(always_on_group_en_o),
    .switchable_group_en_o(switchable_group_en_o),
    .discharge_en_o(discharge_en_o),
    .long_power_reset_n_o(long_power_reset_n_o),
    .short_processor_reset_n_o(short_processor_reset_n_o),
    .charger_enable_o(charger_enable_o),
    .charger_sleep_o(charger_sleep_o),
    .charge_indicator_o(charge_indicator_o)
);

// file: verif/pps_host_model.sv
// Host processor and rail settling model facing the sequencer.
module pps_host_model (
    input logic sys_clk_i,
    input logic rst_n_i,
    input logic slow_i,
    input pps_pkg::pps_path_s path_i,
    input logic [2:0] aon_en_i,
    input logic [2:0] sw_en_i,
    input logic long_n_i,
    output logic rail_good_o,
    output logic aon_good_o,
    output logic sw_good_o,
    output logic sw_enable_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] lim, rc, ac, sc, hc;
    assign lim = slow_i ? 4'hC : 4'h3;
    // Goods rise a settling time after their enable, drop at once
    always_ff @(posedge sys_clk_i) begin
        rc <= (!rst_n_i || !(path_i.rail_from_adapter
              || path_i.rail_from_battery)) ? 4'h0 : rc + 4'(rc < lim);
        ac <= (!rst_n_i || aon_en_i != 3'h7) ? 4'h0 : ac + 4'(ac < lim);
        sc <= (!rst_n_i || sw_en_i != 3'h7) ? 4'h0 : sc + 4'(sc < lim);
        hc <= (!rst_n_i || !long_n_i) ? 4'h0 : hc + 4'(hc != 4'hF);
    end
    assign rail_good_o = rc >= lim;
    assign aon_good_o = ac >= lim;
    assign sw_good_o = sc >= lim;
    // Host staggers: switchable group only well after long reset release
    assign sw_enable_n_o = hc != 4'hF;
endmodule : pps_host_model

// file: verif/tb_pps_sequencer.sv
// Self-checking bench for the power-path sequencer.
module tb_pps_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned DOWN = 32'd300;
    logic clk, rst_n, wr_en, rd_en, rd_d, req_n, aon_n, con, val, battery_terminal;
    logic psel, slow, rail_g, aon_g, sw_g, sw_n, long_n, short_n;
    logic c_en, c_sl, c_in;
    logic [7:0] addr;
    logic [31:0] wr_data, rd_data;
    logic [2:0] aon_en, sw_en;
    logic [5:0] dis;
    pps_pkg::pps_pins_s pins;
    pps_pkg::pps_path_s path;
    logic [31:0] exp_q[$];
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    integer seed = 32'h8D10;
    assign pins = {req_n, aon_n, sw_n, con, val, battery_terminal, psel, rail_g, aon_g,
        sw_g};
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    pps_sequencer #(.LONG_RESET_CYCLES(40), .SHORT_RESET_CYCLES(10),
        .POWER_DOWN_CYCLES(DOWN)) dut (.sys_clk_i(clk), .rst_n_i(rst_n),
        .pins_i(pins), .addr_i(addr), .wr_data_i(wr_data), .wr_en_i(wr_en),
        .rd_en_i(rd_en), .rd_data_o(rd_data), .path_o(path),
        .always_on_group_en_o(aon_en), .switchable_group_en_o(sw_en),
        .discharge_en_o(dis), .long_power_reset_n_o(long_n),
        .short_processor_reset_n_o(short_n), .charger_enable_o(c_en),
        .charger_sleep_o(c_sl), .charge_indicator_o(c_in));
    pps_host_model u_host (.sys_clk_i(clk), .rst_n_i(rst_n), .slow_i(slow),
        .path_i(path), .aon_en_i(aon_en), .sw_en_i(sw_en), .long_n_i(long_n),
        .rail_good_o(rail_g), .aon_good_o(aon_g), .sw_good_o(sw_g),
        .sw_enable_n_o(sw_n));
    task automatic check(input logic [31:0] seen, exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic give_verdict();
        $display("compared %0d mismatched %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr
    // Expected read data is queued here and compared by the monitor
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd_en <= 1'b0;
    endtask : rd
    // Waits a bounded time for a reset output to reach a level
    task automatic wait_rst(input bit sel, input logic lvl, input int lim);
        for (int i = 0; i < lim; i++) begin
            @(negedge clk);
            if ((sel ? short_n : long_n) === lvl) break;
        end
        check(sel ? short_n : long_n, lvl, "reset level");
        @(posedge clk);
    endtask : wait_rst
    function automatic logic [31:0] st(input logic [4:0] s,
        input logic lat, ra, rb, lr, sr);
        return {19'h0, sr, lr, rb, ra, lat, 3'h0, s};
    endfunction : st
    // Read data stands only in the cycle after the strobe
    always @(posedge clk) rd_d <= rd_en;
    always @(negedge clk) begin
        if (rd_d === 1'b1) begin
            check(rd_data, exp_q.pop_front(), "read");
        end
    end
    // Run ceiling, far above the fewer than two thousand cycles the tests take
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            give_verdict();
        end
    end
    initial begin
        {rst_n, wr_en, rd_en, addr, wr_data} = '0;
        {req_n, aon_n, con, val, battery_terminal, psel, slow} = 7'h44;
        idle(6);
        rst_n <= 1'b1;
        @(negedge clk);
        check(dis, 6'h3F, "discharge");
        check({long_n, short_n, c_en, c_sl, c_in}, 5'h02, "reset outs");
        check(path, 4'h0, "path");
        rd(8'h04, st(5'h01, 0, 0, 0, 0, 0));
        wr(8'h08, 32'hFFFFFFFF);
        rd(8'h08, 32'h0);
        rd(8'h00, 32'h0);
        $display("reset test done");
        req_n <= 1'b0;
        idle(4);
        req_n <= 1'b1;
        wait_rst(1, 1, 400);
        rd(8'h04, st(5'h10, 1, 0, 1, 1, 1));
        check(path, 4'h5, "battery path");
        wait_rst(0, 0, DOWN + 50);
        rd(8'h04, st(5'h01, 0, 0, 0, 0, 0));
        check(dis, 6'h3F, "discharge");
        $display("battery start test done");
        {con, val, slow} <= 3'h7;
        wait_rst(1, 1, 600);
        rd(8'h04, st(5'h10, 0, 1, 0, 1, 1));
        check({path, c_en, c_in, c_sl}, 7'h56, "adapter outs");
        idle(DOWN + 20);
        rd(8'h04, st(5'h10, 0, 1, 0, 1, 1));
        psel <= 1'b1;
        idle(6);
        rd(8'h04, st(5'h10, 0, 0, 1, 1, 1));
        psel <= 1'b0;
        wr(8'h00, 32'($random(seed)) | 32'h00000001);
        rd(8'h00, 32'h1);
        rd(8'h04, st(5'h10, 0, 0, 1, 1, 1));
        wr(8'h00, 32'h0);
        idle(4);
        rd(8'h04, st(5'h10, 0, 1, 0, 1, 1));
        $display("adapter path test done");
        val <= 1'b0;
        idle(8);
        rd(8'h04, st(5'h10, 0, 0, 1, 1, 1));
        check({path, c_sl}, 5'hB, "sag outs");
        val <= 1'b1;
        idle(6);
        req_n <= 1'b0;
        idle(4);
        req_n <= 1'b1;
        idle(4);
        rd(8'h04, st(5'h10, 1, 1, 0, 1, 1));
        {con, val} <= 2'h0;
        idle(8);
        rd(8'h04, st(5'h10, 1, 0, 1, 1, 1));
        wait_rst(0, 0, DOWN + 50);
        $display("sag and latch test done");
        {aon_n, con, val, slow} <= 4'hE;
        idle(20);
        check({aon_en, long_n}, 4'h0, "group gated");
        aon_n <= 1'b0;
        wait_rst(1, 1, 600);
        {con, val} <= 2'h0;
        wait_rst(0, 0, 20);
        rd(8'h04, st(5'h01, 0, 0, 0, 0, 0));
        idle(4);
        $display("removal test done");
        give_verdict();
    end
endmodule : tb_pps_sequencer
